//--- hw/vic_arbiter.sv
// Purpose: picks the most urgent eligible vector
// Assumes: lower priority number is more urgent
// Notes:   purely combinational; ties go to the lower vector number
`timescale 1ns/1ps
`default_nettype none
module vic_arbiter import vic_pkg::*; #(
  parameter int NVEC = 32,
  parameter int PW   = 3
) (
  input  wire logic [NVEC-1:0]         elig,
  input  wire logic [NVEC-1:0][PW-1:0] prio,
  output logic                         found,
  output logic [VIC_VEC_W-1:0]         win_vec,
  output logic [PW-1:0]                win_prio
);

  initial begin
    if (NVEC > (1 << VIC_VEC_W) || PW < 1) begin
      $error("vic_arbiter: unsupported NVEC or PW");
    end
  end

  // scan downwards with <= so the lowest index wins a tie
  always_comb begin
    found    = 1'b0;
    win_vec  = '0;
    win_prio = '0;
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (elig[i] && (!found || prio[i] <= win_prio)) begin
        found    = 1'b1;
        win_vec  = VIC_VEC_W'(i);
        win_prio = prio[i];
      end
    end
  end

endmodule
`default_nettype wire

//--- hw/vic_pkg.sv
// Purpose: shared constants and types of the vectored interrupt controller
// Assumes: 32 vectors, eight priority levels, 16-bit service-routine addresses
// Notes:   byte offsets below are AXI4-Lite byte addresses of the register file
package vic_pkg;

  localparam int VIC_NVEC       = 32;
  localparam int VIC_PRIO_W     = 3;
  localparam int VIC_ISR_W      = 16;
  localparam int VIC_VEC_W      = 5;
  localparam int VIC_NEST_MAX   = 8;
  localparam int VIC_ADDR_W     = 8;

  // phase lengths in clocks
  localparam logic [2:0] VIC_EVAL_CYC   = 3'h3;
  localparam logic [2:0] VIC_BRANCH_CYC = 3'h7;

  // register byte offsets
  localparam logic [7:0] VIC_OFF_ENABLE   = 8'h00;
  localparam logic [7:0] VIC_OFF_PENDING  = 8'h04;
  localparam logic [7:0] VIC_OFF_PENDING_FLAG_SET = 8'h08;
  localparam logic [7:0] VIC_OFF_POSTED   = 8'h0C;
  localparam logic [7:0] VIC_OFF_STATUS   = 8'h10;
  localparam logic [7:0] VIC_OFF_SRC_LO   = 8'h14;
  localparam logic [7:0] VIC_OFF_SRC_HI   = 8'h18;
  localparam logic [7:0] VIC_OFF_PRIO0    = 8'h20;
  localparam logic [7:0] VIC_OFF_PRIO3    = 8'h2C;
  localparam logic [7:0] VIC_OFF_ISR_BASE = 8'h80;

  // values after reset
  localparam logic [31:0] VIC_RST_ENABLE = 32'h0000_0000;
  localparam logic [1:0]  VIC_RST_SRC    = 2'h0;
  localparam logic [2:0]  VIC_RST_PRIO   = 3'h7;
  localparam logic [15:0] VIC_RST_ISR    = 16'h0000;

  localparam logic [1:0] VIC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] VIC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    VIC_SRC_FIXED  = 2'b00,
    VIC_SRC_DMA    = 2'b01,
    VIC_SRC_FABRIC = 2'b10,
    VIC_SRC_OFF    = 2'b11
  } vic_src_e;

  typedef enum logic [2:0] {
    VIC_IDLE   = 3'b000,
    VIC_EVAL   = 3'b001,
    VIC_REQ    = 3'b010,
    VIC_ACK    = 3'b011,
    VIC_BRANCH = 3'b100
  } vic_state_e;

  typedef struct packed {
    logic                  valid;
    logic [VIC_PRIO_W-1:0] prio;
    logic [VIC_VEC_W-1:0]  vec;
  } vic_frame_s;

  typedef struct packed {
    logic [VIC_VEC_W-1:0] vector;
    logic [VIC_ISR_W-1:0] isr_address;
  } vic_cpu_req_s;

  typedef struct packed {
    logic [31:0]                           enable;
    logic [31:0]                           pending;
    logic [31:0]                           posted;
    logic [31:0]                           src_prev;
    logic [VIC_NVEC-1:0][1:0]              src_sel;
    logic [VIC_NVEC-1:0][VIC_PRIO_W-1:0]   prio;
    logic [VIC_NVEC-1:0][VIC_ISR_W-1:0]    isr_tab;
    vic_state_e                            state;
    logic [2:0]                            cnt;
    logic                                  req;
    vic_cpu_req_s                          cpu;
    logic [VIC_PRIO_W-1:0]                 win_prio;
    vic_frame_s                            act;
    logic [VIC_NEST_MAX-1:0][8:0]          stk;
    logic [3:0]                            depth;
    logic                                  aw_got;
    logic                                  w_got;
    logic [VIC_ADDR_W-1:0]                 aw_addr;
    logic [31:0]                           wdata;
    logic [3:0]                            wstrb;
    logic                                  bvalid;
    logic [1:0]                            bresp;
    logic                                  rvalid;
    logic [31:0]                           rdata;
    logic [1:0]                            rresp;
  } vic_regs_s;

endpackage

//--- hw/vic_top.sv
// Purpose: 32-vector prioritised interrupt controller with AXI4-Lite registers
// Assumes: all source inputs synchronous to aclk; core pulses its acknowledge
// Notes:   priority 0 is most urgent; nesting stack holds eight frames
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vic_top import vic_pkg::*; #(
  parameter int NVEC = 32
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [VIC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [VIC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [31:0]           fixed_irq,
  input  wire logic [15:0]           dma_terminal_out_group0,
  input  wire logic [15:0]           dma_terminal_out_group1,
  input  wire logic [31:0]           fabric_irq,
  output logic                       irq_request,
  output vic_cpu_req_s               cpu_req,
  input  wire logic                  request_acknowledge,
  input  wire logic                  service_complete
);

  initial begin
    if (NVEC != VIC_NVEC) begin
      $error("vic_top: only 32 vectors are supported");
    end
  end

  vic_regs_s r;
  vic_regs_s next_r;

  logic [31:0]                         src_level;
  logic [31:0]                         elig;
  logic                                arb_found;
  logic [VIC_VEC_W-1:0]                arb_vec;
  logic [VIC_PRIO_W-1:0]               arb_prio;
  logic                                push;
  logic                                pop;

  // per-vector source selection
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_vec
      logic fixed_line;
      logic dma_line;
      // vectors 2 and 26 have no fixed peripheral behind them
      assign fixed_line = (g == 2 || g == 26) ? 1'b0 : fixed_irq[g];
      // each channel's two terminal outputs land in group 0 and group 1
      assign dma_line = (g < 16) ? dma_terminal_out_group0[g % 16]
                                 : dma_terminal_out_group1[g % 16];
      always_comb begin
        unique case (vic_src_e'(r.src_sel[g]))
          VIC_SRC_FIXED:  src_level[g] = fixed_line;
          VIC_SRC_DMA:    src_level[g] = dma_line;
          // routed fabric lines let any signal reach any vector
          VIC_SRC_FABRIC: src_level[g] = fabric_irq[g];
          VIC_SRC_OFF:    src_level[g] = 1'b0;
        endcase
      end
      // only strictly more urgent work may preempt, and only while stack room remains
      assign elig[g] = r.posted[g] && r.enable[g] && (r.depth < 4'(VIC_NEST_MAX))
                       && (!r.act.valid || r.prio[g] < r.act.prio);
    end
  endgenerate

  vic_arbiter #(
    .NVEC (32),
    .PW   (VIC_PRIO_W)
  ) u_arb (
    .elig     (elig),
    .prio     (r.prio),
    .found    (arb_found),
    .win_vec  (arb_vec),
    .win_prio (arb_prio)
  );

  function automatic logic [31:0] rd_word(input vic_regs_s s, input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    if (a >= VIC_OFF_ISR_BASE) begin
      v = {16'h0000, s.isr_tab[a[6:2]]};
    end else if (a >= VIC_OFF_PRIO0 && a <= VIC_OFF_PRIO3) begin
      for (int j = 0; j < 8; j++) begin
        v[4*j +: 3] = s.prio[{a[3:2], 3'(j)}];
      end
    end else begin
      case (a)
        VIC_OFF_ENABLE:  v = s.enable;
        VIC_OFF_PENDING: v = s.pending;
        VIC_OFF_POSTED:  v = s.posted;
        VIC_OFF_STATUS:  v = {16'h0000, s.depth, s.act.valid, s.act.prio, s.act.vec, s.state};
        VIC_OFF_SRC_LO:  v = s.src_sel[15:0];
        VIC_OFF_SRC_HI:  v = s.src_sel[31:16];
        default:         v = '0;
      endcase
    end
    return v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    logic m;
    m = (a[1:0] == 2'h0) && ((a >= VIC_OFF_ISR_BASE) || (a <= VIC_OFF_SRC_HI)
        || (a >= VIC_OFF_PRIO0 && a <= VIC_OFF_PRIO3));
    return m;
  endfunction

  always_comb begin
    logic [31:0] m;
    logic [31:0] wv;
    logic [31:0] sw_set;
    logic [31:0] sw_clr;
    logic [31:0] ack_clr;
    logic [31:0] posted_flag_clr;
    logic [31:0] edges;
    m        = '0;
    wv       = '0;
    sw_set   = '0;
    sw_clr   = '0;
    ack_clr  = '0;
    posted_flag_clr = '0;
    push     = 1'b0;
    pop      = 1'b0;
    next_r   = r;

    // register writes: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_got  = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      m = {{8{r.wstrb[3]}}, {8{r.wstrb[2]}}, {8{r.wstrb[1]}}, {8{r.wstrb[0]}}};
      wv = (rd_word(r, r.aw_addr) & ~m) | (r.wdata & m);
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = mapped(r.aw_addr) ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
      if (r.aw_addr >= VIC_OFF_ISR_BASE) begin
        next_r.isr_tab[r.aw_addr[6:2]] = wv[15:0];
      end else if (r.aw_addr >= VIC_OFF_PRIO0 && r.aw_addr <= VIC_OFF_PRIO3) begin
        for (int j = 0; j < 8; j++) begin
          next_r.prio[{r.aw_addr[3:2], 3'(j)}] = wv[4*j +: 3];
        end
      end else begin
        case (r.aw_addr)
          VIC_OFF_ENABLE:   next_r.enable = wv;
          VIC_OFF_PENDING:  sw_clr = r.wdata & m;
          VIC_OFF_PENDING_FLAG_SET: sw_set = r.wdata & m;
          VIC_OFF_SRC_LO:   next_r.src_sel[15:0] = wv;
          VIC_OFF_SRC_HI:   next_r.src_sel[31:16] = wv;
          default:          ;
        endcase
      end
    end

    // register reads; reads have no side effects
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = rd_word(r, s_axi_araddr);
      next_r.rresp  = mapped(s_axi_araddr) ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
    end

    // nesting: pop on completion, push on acknowledge
    if (service_complete && r.depth != 4'h0) begin
      pop = 1'b1;
      next_r.act   = vic_frame_s'(r.stk[r.depth[2:0] - 3'h1]);
      next_r.depth = r.depth - 4'h1;
    end

    unique case (r.state)
      VIC_IDLE: begin
        if (|elig) begin
          next_r.state = VIC_EVAL;
          next_r.cnt   = '0;
        end
      end
      VIC_EVAL: begin
        next_r.cnt = r.cnt + 3'h1;
        if (r.cnt == VIC_EVAL_CYC - 3'h1) begin
          if (arb_found) begin
            next_r.state           = VIC_REQ;
            next_r.req             = 1'b1;
            next_r.cpu.vector      = arb_vec;
            next_r.cpu.isr_address = r.isr_tab[arb_vec];
            next_r.win_prio        = arb_prio;
          end else begin
            next_r.state = VIC_IDLE;
          end
        end
      end
      VIC_REQ: begin
        if (request_acknowledge) begin
          push = 1'b1;
          ack_clr[r.cpu.vector] = 1'b1;
          next_r.req   = 1'b0;
          next_r.state = VIC_ACK;
        end
      end
      VIC_ACK: begin
        posted_flag_clr[r.cpu.vector] = 1'b1;
        next_r.state = VIC_BRANCH;
        next_r.cnt   = '0;
      end
      VIC_BRANCH: begin
        next_r.cnt = r.cnt + 3'h1;
        if (r.cnt == VIC_BRANCH_CYC - 3'h1) begin
          next_r.state = VIC_IDLE;
        end
      end
      default: begin
        next_r.state = VIC_IDLE;
        next_r.req   = 1'b0;
      end
    endcase

    // a frame saved below the newly taken vector; uses the state after any pop
    if (push) begin
      next_r.stk[next_r.depth[2:0]] = 9'(next_r.act);
      next_r.depth = next_r.depth + 4'h1;
      next_r.act   = '{valid: 1'b1, prio: r.win_prio, vec: r.cpu.vector};
    end

    // new arrivals win over any clear in the same clock
    next_r.src_prev = src_level;
    edges = src_level & ~r.src_prev;
    next_r.pending = (r.pending & ~sw_clr & ~ack_clr) | edges | sw_set;
    next_r.posted  = (r.posted & ~sw_clr & ~posted_flag_clr) | (r.pending & r.enable);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r          <= '0;
      r.enable   <= VIC_RST_ENABLE;
      r.src_sel  <= {VIC_NVEC{VIC_RST_SRC}};
      r.prio     <= {VIC_NVEC{VIC_RST_PRIO}};
      r.isr_tab  <= {VIC_NVEC{VIC_RST_ISR}};
      r.state    <= VIC_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready  = !r.w_got && !r.bvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign irq_request   = r.req;
  assign cpu_req       = r.cpu;

  // checks
  logic [31:0] edge_now;
  logic [31:0] posted_flag_due;
  assign edge_now = src_level & ~r.src_prev;
  assign posted_flag_due = r.pending & r.enable;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_PENDING_FLAG_CAPTURE: assert property ((|edge_now) |=>
    ((r.pending & $past(edge_now)) == $past(edge_now)))
    else $error("source edge did not set pending");
  AST_POSTED_FLAG_FOLLOW: assert property ((|posted_flag_due) |=>
    ((r.posted & $past(posted_flag_due)) == $past(posted_flag_due)))
    else $error("pending vector was not posted");
  AST_EVAL_LEN: assert property ($rose(r.req) |->
    ($past(r.state, 1) == VIC_EVAL && $past(r.state, 3) == VIC_EVAL
     && $past(r.state, 4) != VIC_EVAL))
    else $error("evaluation did not last three clocks");
  AST_ADDR_MATCH: assert property (r.req |->
    (r.cpu.isr_address == r.isr_tab[r.cpu.vector]))
    else $error("presented address does not match vector");
  AST_ACK_SEQ: assert property ((r.state == VIC_REQ && request_acknowledge) |=>
    (r.state == VIC_ACK && !r.req) ##1 (r.state == VIC_BRANCH))
    else $error("acknowledge sequence wrong");
  AST_BRANCH_LEN: assert property ($rose(r.state == VIC_BRANCH) |->
    (r.state == VIC_BRANCH)[*7] ##1 (r.state == VIC_IDLE))
    else $error("branch phase not seven cycles");
  AST_RESTORE: assert property ((pop && !push) |=>
    (r.act == $past(vic_frame_s'(r.stk[r.depth[2:0] - 3'h1]))))
    else $error("active status not restored");
  AST_PREEMPT: assert property ($rose(r.req) |->
    (!r.act.valid || r.win_prio < r.act.prio))
    else $error("request does not outrank active interrupt");
  AST_DEPTH: assert property (r.depth <= 4'(VIC_NEST_MAX))
    else $error("nesting deeper than eight");
  // own disable: the default one would switch this check off during reset
  AST_RESET: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
    (!r.req && r.pending == '0 && r.posted == '0 && !r.act.valid))
    else $error("reset left state behind");

  COV_REQUEST: cover property ($rose(r.req));
  COV_NESTED:  cover property (r.depth == 4'h2);
  COV_RETURN:  cover property (pop);

endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: core model acknowledges; bench drives sources and registers
// Notes:   all stimulus by non-blocking assignment just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module testbench import vic_pkg::*;;
  localparam logic [1:0]  OK  = VIC_RESP_OKAY;
  localparam logic [1:0]  ER  = VIC_RESP_SLVERR;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic         aclk    = 1'b0;
  logic         aresetn = 1'b0;
  logic         awvalid = 1'b0;
  logic         wvalid  = 1'b0;
  logic         bready  = 1'b0;
  logic         arvalid = 1'b0;
  logic         rready  = 1'b0;
  logic         sc      = 1'b0;
  logic [7:0]   awaddr  = 8'h00;
  logic [7:0]   araddr  = 8'h00;
  logic [31:0]  wdata   = 32'h0000_0000;
  logic [31:0]  fix     = 32'h0000_0000;
  logic [31:0]  fab     = 32'h0000_0000;
  logic [15:0]  dma0    = 16'h0000;
  logic [15:0]  dma1    = 16'h0000;
  logic [3:0]   ack_dly = 4'h0;
  logic         awready, wready, bvalid, arready, rvalid, irq, ack;
  logic [31:0]  rdata;
  logic [1:0]   bresp, rresp;
  vic_cpu_req_s creq, taken;
  int           bad_count = 0;
  int           tests_run = 0;

  vic_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fixed_irq(fix), .dma_terminal_out_group0(dma0),
    .dma_terminal_out_group1(dma1), .fabric_irq(fab), .irq_request(irq),
    .cpu_req(creq), .request_acknowledge(ack), .service_complete(sc));

  vic_cpu_model core (.aclk(aclk), .aresetn(aresetn), .irq_request(irq),
    .cpu_req(creq), .service_complete(sc), .ack_delay(ack_dly),
    .request_acknowledge(ack), .taken(taken));

  initial begin
    forever #2 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_up(input string what);
    bad_count++;
    $display("MISMATCH %0t timeout in %s", $time, what);
    complete_run();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (n >= 100) give_up("write");
    check({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m,
                        input logic [31:0] e);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (n >= 100) give_up("read");
    check({30'h0, rresp}, {30'h0, er}, "rresp");
    check(rdata & m, e, "rdata");
  endtask

  // waits for a request, then for the core to take it and branch
  task automatic take(input logic [4:0] v, input logic [15:0] isr, output int n);
    int k;
    n = 0;
    k = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!irq && n < 200);
    if (n >= 200) give_up("request");
    check(32'(creq), {11'h0, v, isr}, "vector");
    while (irq && k < 50) begin
      @(negedge aclk);
      k++;
    end
    if (k >= 50) give_up("acknowledge");
    repeat (12) @(posedge aclk);
    check(32'(taken), {11'h0, v, isr}, "taken");
  endtask

  task automatic quiet(input int c);
    logic seen;
    seen = 1'b0;
    repeat (c) begin
      @(negedge aclk);
      seen = seen | irq;
    end
    @(posedge aclk);
    check({31'h0, seen}, 32'h0, "no request");
  endtask

  task automatic end_isr();
    sc <= 1'b1;
    @(posedge aclk);
    sc <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_reset();
    check({31'h0, irq}, 32'h0, "request idle");
    rd_chk(VIC_OFF_ENABLE, OK, ALL, 32'h0);
    rd_chk(VIC_OFF_PENDING, OK, ALL, 32'h0);
    rd_chk(VIC_OFF_POSTED, OK, ALL, 32'h0);
    rd_chk(VIC_OFF_STATUS, OK, ALL, 32'h0);
    rd_chk(VIC_OFF_PRIO3, OK, 32'h7777_7777, 32'h7777_7777);
    axi_wr(8'h40, 32'h0000_0001, ER);
    rd_chk(8'h40, ER, ALL, 32'h0);
  endtask

  task automatic t_fixed();
    int n;
    axi_wr(VIC_OFF_ISR_BASE + 8'h14, 32'h0000_1234, OK);
    axi_wr(VIC_OFF_ENABLE, 32'h0000_0020, OK);
    fix <= 32'h0000_0020;
    take(5'h05, 16'h1234, n);
    // six edges to the request, plus the half cycle before the first negedge
    check(32'(n), 32'h7, "latency");
    rd_chk(VIC_OFF_PENDING, OK, ALL, 32'h0);
    rd_chk(VIC_OFF_POSTED, OK, ALL, 32'h0);
    rd_chk(VIC_OFF_STATUS, OK, 32'h0000_fff8, 32'h0000_1f28);
    fix <= 32'h0000_0000;
    end_isr();
    rd_chk(VIC_OFF_STATUS, OK, 32'h0000_f800, 32'h0);
  endtask

  // equal levels wait; a more urgent DMA vector preempts the running one
  task automatic t_nest();
    int n;
    axi_wr(VIC_OFF_SRC_LO, 32'h0008_0080, OK);
    axi_wr(VIC_OFF_SRC_HI, 32'h0000_0100, OK);
    axi_wr(VIC_OFF_PRIO0 + 8'h08, 32'h7770_7777, OK);
    axi_wr(VIC_OFF_ISR_BASE + 8'h0c, 32'h0000_0300, OK);
    axi_wr(VIC_OFF_ISR_BASE + 8'h24, 32'h0000_0900, OK);
    axi_wr(VIC_OFF_ISR_BASE + 8'h50, 32'h0000_2000, OK);
    axi_wr(VIC_OFF_ENABLE, 32'h0010_0208, OK);
    ack_dly <= 4'h9;
    fab <= 32'h0000_0208;
    take(5'h03, 16'h0300, n);
    quiet(40);
    end_isr();
    take(5'h09, 16'h0900, n);
    dma1 <= 16'h0010;
    take(5'h14, 16'h2000, n);
    rd_chk(VIC_OFF_STATUS, OK, 32'h0000_fff8, 32'h0000_28a0);
    end_isr();
    end_isr();
    rd_chk(VIC_OFF_STATUS, OK, 32'h0000_f800, 32'h0);
    fab <= 32'h0000_0000;
    dma1 <= 16'h0000;
  endtask

  task automatic t_soft();
    int n;
    axi_wr(VIC_OFF_ENABLE, 32'h0000_0004, OK);
    fix <= 32'h0000_0004;
    axi_wr(VIC_OFF_PENDING_FLAG_SET, 32'h0000_0080, OK);
    rd_chk(VIC_OFF_PENDING, OK, ALL, 32'h0000_0080);
    quiet(20);
    axi_wr(VIC_OFF_PENDING, 32'h0000_0080, OK);
    rd_chk(VIC_OFF_PENDING, OK, ALL, 32'h0);
    axi_wr(VIC_OFF_ENABLE, 32'h0000_0080, OK);
    axi_wr(VIC_OFF_SRC_LO, 32'h0000_c000, OK);
    fix <= 32'h0000_0084;
    quiet(10);
    ack_dly <= 4'h0;
    axi_wr(VIC_OFF_PENDING_FLAG_SET, 32'h0000_0080, OK);
    take(5'h07, 16'h0000, n);
    end_isr();
    fix <= 32'h0000_0000;
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_fixed();
    t_nest();
    t_soft();
    complete_run();
  end
endmodule
`default_nettype wire

//--- testbench/vic_cpu_model.sv
// Purpose: behavioural core that takes requests from the controller
// Assumes: acknowledge is one cycle, ack_delay + 1 cycles after the request
// Notes:   program counter is a free count; return stack is a queue
`timescale 1ns/1ps
`default_nettype none
module vic_cpu_model import vic_pkg::*; (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         irq_request,
  input  wire vic_cpu_req_s cpu_req,
  input  wire logic         service_complete,
  input  wire logic [3:0]   ack_delay,
  output logic              request_acknowledge,
  output vic_cpu_req_s      taken
);
  logic [15:0] pc;
  logic [3:0]  wait_cnt;
  logic [15:0] pc_stack[$];
  always @(posedge aclk) begin
    if (!aresetn) begin
      request_acknowledge <= 1'b0;
      taken <= '0;
      pc <= 16'h0000;
      wait_cnt <= 4'h0;
      pc_stack.delete();
    end else begin
      request_acknowledge <= 1'b0;
      pc <= pc + 16'h0001;
      // slow answers model a long instruction still in flight
      if (irq_request && !request_acknowledge) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == ack_delay) begin
          request_acknowledge <= 1'b1;
          taken <= cpu_req;
          pc_stack.push_back(pc);
          pc <= cpu_req.isr_address;
          wait_cnt <= 4'h0;
        end
      end
      if (service_complete && pc_stack.size() > 0) begin
        pc <= pc_stack.pop_back() + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire
